// *** inc/ssat_cap_if.sv ***
// Carrier from the shared conversion timer to the channel captures.
// Assumes one clock; all members are driven by the timer side.
`timescale 1ns/1ps
`default_nettype none
interface ssat_cap_if;
   logic [11:0] timer; // Shared conversion count
   logic run; // Ramp charging, trips are valid
   logic restart; // One-cycle pulse at each ramp restart
   modport ctrl (output timer, output run, output restart);
   modport chan (input timer, input run, input restart);
endinterface
`default_nettype wire

// *** inc/ssat_pkg.sv ***
// Shared constants of the single-slope converter timer.
// Assumes a 10 MHz core clock; all register offsets are byte addresses.
package ssat_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS = 100; // Core clock period
   localparam int SYNC_MIN_NS = 50; // Shortest restart pulse
   localparam int SYNC_MAX_NS = 12500; // Longest restart pulse
   // Least time rounds up, never below one cycle
   localparam int SYNC_MIN_CYC_RAW = (SYNC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_MIN_CYC = (SYNC_MIN_CYC_RAW < 1) ? 1 : SYNC_MIN_CYC_RAW;
   // Longest time rounds down
   localparam int SYNC_MAX_CYC = SYNC_MAX_NS / CLK_PERIOD_NS;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADR_MODE = 8'h00; // Mode control word
   localparam logic [7:0] ADR_WIDTH = 8'h04; // Sync pulse width
   localparam logic [7:0] ADR_TRIM = 8'h08; // Ramp current setting
   localparam logic [7:0] ADR_PERIOD = 8'h0c; // Sync period
   localparam logic [7:0] ADR_CAP_ONE = 8'h10; // Capture channel one
   localparam logic [7:0] ADR_CAP_TWO = 8'h14; // Capture channel two
   localparam logic [7:0] ADR_CAP_THREE = 8'h18; // Capture channel three
   localparam logic [7:0] ADR_CAP_AUX = 8'h1c; // Capture auxiliary channel
   localparam logic [7:0] ADR_STATUS = 8'h20; // Live timer and sync state

   // ==========================================================
   // Field positions
   localparam int MODE_AUX_LOW_BIT = 0; // Aux select low
   localparam int MODE_AUX_HIGH_BIT = 1; // Aux select high
   localparam int MODE_DOUBLE_BIT = 2; // Double update operation
   localparam int MODE_RATE_BIT = 7; // Count rate select
   localparam int STATUS_SYNC_BIT = 16; // Restart pulse active

   // ==========================================================
   // Reset values
   localparam logic [1:0] RST_AUX_SEL = 2'h0;
   localparam logic RST_RATE = 1'b0;
   localparam logic RST_DOUBLE = 1'b0;
   localparam logic [2:0] RST_TRIM = 3'h0;
   localparam logic [7:0] RST_WIDTH = 8'h14; // 2 us
   localparam logic [15:0] RST_PERIOD = 16'h0fa0; // 400 us

   // ==========================================================
   // Auxiliary selector codes
   localparam logic [1:0] AUX_SEL_ZERO = 2'h0;
   localparam logic [1:0] AUX_SEL_ONE = 2'h1;
   localparam logic [1:0] AUX_SEL_TWO = 2'h2;
   localparam logic [1:0] AUX_SEL_REF = 2'h3;

   localparam logic [11:0] TIMER_MAX = 12'hfff; // 4095
endpackage

// *** logic/ssat_capture.sv ***
// One channel capture: latches the first trip, publishes at restart.
// Assumes the trip input is already synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module ssat_capture
   import ssat_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   ssat_cap_if.chan cap,
   input wire logic trip_i,
   output logic [11:0] result_o
);
   // ==========================================================
   // State
   typedef struct packed {
      logic hit; // A trip was seen since the last restart
      logic [11:0] latch; // Count at first trip
      logic [11:0] result; // Published result
   } ssat_cap_st_t;

   ssat_cap_st_t st_q;
   ssat_cap_st_t st_d;

   // Next state
   always_comb begin
      st_d = st_q;
      if (cap.restart) begin
         // Publish and rearm; no trip means zero
         st_d.result = st_q.hit ? st_q.latch : 12'h000;
         st_d.hit = 1'b0;
      end else if (cap.run && trip_i && !st_q.hit) begin
         // First trip only
         st_d.latch = cap.timer;
         st_d.hit = 1'b1;
      end
   end

   // Registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign result_o = st_q.result;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_cap_zero: assert property (cap.restart && !st_q.hit |=> result_o == 12'h000)
      else $error("missed trip did not report zero");
   a_cap_value: assert property (cap.restart && st_q.hit |=> result_o == $past(st_q.latch))
      else $error("capture did not publish latched count");
   a_cap_hold: assert property (!cap.restart |=> $stable(result_o))
      else $error("capture changed between restarts");
   a_cap_first: assert property (st_q.hit && !cap.restart |=> $stable(st_q.latch))
      else $error("later trip overwrote first");
   c_cap_trip: cover property (cap.run && trip_i && !st_q.hit);
endmodule
`default_nettype wire

// *** logic/ssat_top.sv ***
// Digital side of a four-channel single-slope converter.
// Assumes synchronous comparator inputs and a classic Wishbone master.
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module ssat_top
   import ssat_pkg::*;
#(
   parameter int TIMER_W = 12 // Conversion timer width
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Comparator outputs, high once input is below ramp
   input wire logic direct_input_one_i,
   input wire logic direct_input_two_i,
   input wire logic direct_input_three_i,
   input wire logic aux_input_zero_i,
   input wire logic aux_input_one_i,
   input wire logic aux_input_two_i,
   input wire logic aux_reference_i,
   // Analogue side controls
   output logic cycle_sync_pulse_o,
   output logic [1:0] aux_select_o,
   output logic [2:0] ramp_current_setting_o
);
   // ==========================================================
   // Elaboration checks
   if (TIMER_W != 12) begin : g_bad_width
      $error("ssat_top: TIMER_W must be 12");
   end

   // ==========================================================
   // State
   typedef struct packed {
      logic ack; // Bus answer
      logic [31:0] rdata; // Bus read data
      logic aux_select_low; // Selector low bit
      logic aux_select_high; // Selector high bit
      logic double_update; // Two restarts per period
      logic count_rate_select; // Full core rate when set
      logic [2:0] ramp_current_setting; // Current trim code
      logic [7:0] sync_pulse_width; // Width in core cycles
      logic [15:0] period; // Period in core cycles
      logic [15:0] per_cnt; // Position in the period
      logic sync; // Restart pulse active
      logic restart; // First cycle of a pulse
      logic half; // Input clock enable phase
      logic [11:0] timer; // Shared conversion timer
      logic [3:0] trips; // Registered comparator outputs
      logic [7:0] sync_len; // Length of current pulse
   } ssat_top_st_t;

   ssat_top_st_t st_q;
   ssat_top_st_t st_d;

   // Channel results
   logic [11:0] cap_res [4];

   // Selected auxiliary comparator
   logic aux_trip;
   // Width clamped to the legal pulse range
   logic [7:0] width_eff;
   // Midpoint of the period
   logic [15:0] half_per;
   // Offset into the second half
   logic [15:0] second_off;
   // Pulse windows
   logic in_first;
   logic in_second;
   // Timer count enable
   logic cnt_en;
   // Bus request in this cycle
   logic bus_req;

   // ==========================================================
   // Auxiliary selector
   always_comb begin
      // Route one auxiliary comparator to the fourth channel
      case ({st_q.aux_select_high, st_q.aux_select_low})
         AUX_SEL_ZERO: aux_trip = aux_input_zero_i;
         AUX_SEL_ONE: aux_trip = aux_input_one_i;
         AUX_SEL_TWO: aux_trip = aux_input_two_i;
         AUX_SEL_REF: aux_trip = aux_reference_i;
         default: aux_trip = 1'b0;
      endcase
   end

   // ==========================================================
   // Sync window arithmetic
   always_comb begin
      // Keep the pulse inside its documented range
      if (st_q.sync_pulse_width < 8'(SYNC_MIN_CYC)) begin
         width_eff = 8'(SYNC_MIN_CYC);
      end else if (st_q.sync_pulse_width > 8'(SYNC_MAX_CYC)) begin
         width_eff = 8'(SYNC_MAX_CYC);
      end else begin
         width_eff = st_q.sync_pulse_width;
      end
      half_per = {1'b0, st_q.period[15:1]};
      second_off = st_q.per_cnt - half_per;
      in_first = st_q.per_cnt < {8'h00, width_eff};
      // Second restart at the midpoint in double update
      in_second = st_q.double_update && (st_q.per_cnt >= half_per) &&
         (second_off < {8'h00, width_eff});
   end

   assign bus_req = wb_cyc_i && wb_stb_i && !st_q.ack;
   // Input clock is half the core clock
   assign cnt_en = st_q.count_rate_select || st_q.half;

   // ==========================================================
   // Next state
   always_comb begin
      st_d = st_q;
      st_d.ack = bus_req;
      st_d.restart = 1'b0;

      // Period counter wraps at the programmed period
      if (st_q.per_cnt >= st_q.period - 16'h0001) begin
         st_d.per_cnt = 16'h0000;
      end else begin
         st_d.per_cnt = st_q.per_cnt + 16'h0001;
      end

      // Restart pulse and its first cycle
      st_d.sync = in_first || in_second;
      st_d.restart = (in_first || in_second) && !st_q.sync;
      if (st_d.sync) begin
         st_d.sync_len = st_q.sync ? st_q.sync_len + 8'h01 : 8'h01;
      end

      // Comparator sampling, one bit per channel
      st_d.trips = {aux_trip, direct_input_three_i,
         direct_input_two_i, direct_input_one_i};

      // Shared timer held at zero while the ramp discharges
      if (st_q.sync) begin
         st_d.timer = 12'h000;
         st_d.half = 1'b0;
      end else begin
         st_d.half = !st_q.half;
         if (cnt_en && st_q.timer != TIMER_MAX) begin
            st_d.timer = st_q.timer + 12'h001;
         end
      end

      // Register writes
      if (bus_req && wb_we_i) begin
         if (wb_adr_i == ADR_MODE) begin
            if (wb_sel_i[0]) begin
               st_d.aux_select_low = wb_dat_i[MODE_AUX_LOW_BIT];
               st_d.aux_select_high = wb_dat_i[MODE_AUX_HIGH_BIT];
               st_d.double_update = wb_dat_i[MODE_DOUBLE_BIT];
               st_d.count_rate_select = wb_dat_i[MODE_RATE_BIT];
            end
         end else if (wb_adr_i == ADR_WIDTH) begin
            if (wb_sel_i[0]) begin
               st_d.sync_pulse_width = wb_dat_i[7:0];
            end
         end else if (wb_adr_i == ADR_TRIM) begin
            if (wb_sel_i[0]) begin
               st_d.ramp_current_setting = wb_dat_i[2:0];
            end
         end else if (wb_adr_i == ADR_PERIOD) begin
            if (wb_sel_i[0]) begin
               st_d.period[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               st_d.period[15:8] = wb_dat_i[15:8];
            end
         end
      end

      // Register reads, unmapped reads as zero
      st_d.rdata = 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
         if (wb_adr_i == ADR_MODE) begin
            st_d.rdata[MODE_AUX_LOW_BIT] = st_q.aux_select_low;
            st_d.rdata[MODE_AUX_HIGH_BIT] = st_q.aux_select_high;
            st_d.rdata[MODE_DOUBLE_BIT] = st_q.double_update;
            st_d.rdata[MODE_RATE_BIT] = st_q.count_rate_select;
         end else if (wb_adr_i == ADR_WIDTH) begin
            st_d.rdata[7:0] = st_q.sync_pulse_width;
         end else if (wb_adr_i == ADR_TRIM) begin
            st_d.rdata[2:0] = st_q.ramp_current_setting;
         end else if (wb_adr_i == ADR_PERIOD) begin
            st_d.rdata[15:0] = st_q.period;
         end else if (wb_adr_i == ADR_CAP_ONE) begin
            st_d.rdata[11:0] = cap_res[0];
         end else if (wb_adr_i == ADR_CAP_TWO) begin
            st_d.rdata[11:0] = cap_res[1];
         end else if (wb_adr_i == ADR_CAP_THREE) begin
            st_d.rdata[11:0] = cap_res[2];
         end else if (wb_adr_i == ADR_CAP_AUX) begin
            st_d.rdata[11:0] = cap_res[3];
         end else if (wb_adr_i == ADR_STATUS) begin
            st_d.rdata[11:0] = st_q.timer;
            st_d.rdata[STATUS_SYNC_BIT] = st_q.sync;
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
         st_q.aux_select_low <= RST_AUX_SEL[0];
         st_q.aux_select_high <= RST_AUX_SEL[1];
         st_q.double_update <= RST_DOUBLE;
         st_q.count_rate_select <= RST_RATE;
         st_q.ramp_current_setting <= RST_TRIM;
         st_q.sync_pulse_width <= RST_WIDTH;
         st_q.period <= RST_PERIOD;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // Carrier to the captures
   ssat_cap_if cap_bus ();
   assign cap_bus.timer = st_q.timer;
   assign cap_bus.run = !st_q.sync;
   assign cap_bus.restart = st_q.restart;

   // One capture per channel, all on the same timer
   for (genvar ch = 0; ch < 4; ch++) begin : g_chan
      ssat_capture u_cap (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .cap(cap_bus),
         .trip_i(st_q.trips[ch]),
         .result_o(cap_res[ch])
      );
   end

   // ==========================================================
   // Outputs
   assign wb_ack_o = st_q.ack;
   assign wb_dat_o = st_q.rdata;
   assign cycle_sync_pulse_o = st_q.sync;
   assign aux_select_o = {st_q.aux_select_high, st_q.aux_select_low};
   assign ramp_current_setting_o = st_q.ramp_current_setting;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_timer_discharge: assert property (st_q.sync |=> st_q.timer == 12'h000)
      else $error("timer not held at zero during restart");
   a_timer_saturate: assert property (st_q.timer == TIMER_MAX && !st_q.sync
      |=> st_q.timer == TIMER_MAX || st_q.timer == 12'h000)
      else $error("timer passed its ceiling");
   a_rate_full: assert property (st_q.count_rate_select && !st_q.sync && !st_d.sync
      && st_q.timer != TIMER_MAX |=> st_q.timer == $past(st_q.timer) + 12'h001)
      else $error("full rate did not count every cycle");
   a_rate_half: assert property (!st_q.count_rate_select && !$past(st_q.count_rate_select)
      && !st_q.sync && $changed(st_q.timer) |=> !$changed(st_q.timer) || st_q.sync)
      else $error("half rate counted on consecutive cycles");
   a_pulse_width: assert property ($fell(st_q.sync) && $past(st_q.sync_pulse_width, 2)
      == st_q.sync_pulse_width |-> $past(st_q.sync_len) <= width_eff)
      else $error("restart pulse longer than programmed");
   a_aux_route: assert property ({st_q.aux_select_high, st_q.aux_select_low} == AUX_SEL_REF
      && $stable(st_q.aux_select_low) |=> st_q.trips[3] == $past(aux_reference_i))
      else $error("reference not routed to fourth channel");
   a_restart_once: assert property (st_q.restart |-> st_q.sync && !$past(st_q.sync))
      else $error("restart not at pulse start");
   a_trim_reset: assert property (@(posedge clk_i) $past(rst_i) |->
      ramp_current_setting_o == 3'h0)
      else $error("trim not zero after reset");
   a_bus_ack: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not a single cycle");

   c_double_restart: cover property (st_q.double_update && st_q.restart
      && st_q.per_cnt >= half_per);
   c_timer_full: cover property (st_q.timer == TIMER_MAX);
   c_ref_select: cover property (aux_select_o == AUX_SEL_REF && st_q.restart);
endmodule
`default_nettype wire

// *** tb/single_slope_adc_timer_test.sv ***
// Self-checking bench for the converter timer top.
// Assumes a Wishbone register map as in the package and the ramp model.
`timescale 1ns/1ps
`default_nettype none
module single_slope_adc_timer_test;
   import ssat_pkg::*;
   // ==========================================================
   // Stimulus and observed signals
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic cycle_sync_pulse_o;
   logic [1:0] aux_select_o;
   logic [2:0] ramp_current_setting_o;
   logic [6:0][15:0] thr = '0; // Trip ages: ch1..ch3, aux0..aux2, reference
   logic [6:0] comp; // Comparator levels
   int failures = 0;
   int comparisons = 0;

   // 10 MHz core clock
   always #50 clk_i = ~clk_i;

   ssat_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .direct_input_one_i(comp[0]),
      .direct_input_two_i(comp[1]), .direct_input_three_i(comp[2]),
      .aux_input_zero_i(comp[3]), .aux_input_one_i(comp[4]), .aux_input_two_i(comp[5]),
      .aux_reference_i(comp[6]), .cycle_sync_pulse_o(cycle_sync_pulse_o),
      .aux_select_o(aux_select_o), .ramp_current_setting_o(ramp_current_setting_o));

   ssat_ramp_model ramp (.clk_i(clk_i), .rst_i(rst_i), .sync_i(cycle_sync_pulse_o),
      .thr_i(thr), .comp_o(comp));

   // ==========================================================
   // Shared helpers
   task automatic tally_and_finish();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Compare one value and count it
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t ns: %s got %h want %h", $time, msg, got, exp);
      end
   endtask

   // Classic single Wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
         output logic [31:0] rd);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= dat;
      // Wait for the answer however long; only the watchdog ends a hang
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      // Registered answer: taken at the first edge, ack seen at the second
      check(32'(n), 32'd2, "bus answer latency");
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] d;
      wb(1'b1, adr, dat, d);
   endtask

   task automatic rd_check(input logic [7:0] adr, input logic [31:0] exp, input string msg);
      logic [31:0] d;
      wb(1'b0, adr, 32'h0, d);
      check(d, exp, msg);
   endtask

   // Wait at clock edges for a restart pulse level
   task automatic wait_lvl(input logic lvl);
      int n;
      n = 0;
      while (cycle_sync_pulse_o !== lvl && n < 20000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 20000) check(32'h1, 32'h0, "restart pulse stuck");
   endtask

   // One full conversion after the trip ages were set, then captures settle
   task automatic conv();
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      repeat (2) @(posedge clk_i);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      check({30'h0, aux_select_o}, 32'h0, "selector after reset");
      check({29'h0, ramp_current_setting_o}, 32'h0, "trim output after reset");
      rd_check(ADR_TRIM, 32'h0, "trim register after reset");
      rd_check(8'h3c, 32'h0, "unmapped read");
      $display("test reset done");
   endtask

   task automatic t_trim();
      for (int i = 0; i < 8; i++) begin
         wr(ADR_TRIM, 32'(i));
         check({29'h0, ramp_current_setting_o}, 32'(i), "trim output");
         rd_check(ADR_TRIM, 32'(i), "trim readback");
      end
      $display("test trim done");
   endtask

   task automatic t_width();
      int n;
      wr(ADR_PERIOD, 32'd600);
      wr(ADR_WIDTH, 32'd5);
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      n = 0;
      while (cycle_sync_pulse_o === 1'b1 && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      check(32'(n), 32'd5, "restart pulse width");
      rd_check(ADR_WIDTH, 32'd5, "width readback");
      $display("test width done");
   endtask

   task automatic t_concurrent();
      wr(ADR_MODE, 32'h80);
      thr <= {16'd0, 16'd0, 16'd0, 16'd50, 16'd400, 16'd250, 16'd100};
      conv();
      rd_check(ADR_CAP_ONE, 32'd101, "channel one time");
      rd_check(ADR_CAP_TWO, 32'd251, "channel two time");
      rd_check(ADR_CAP_THREE, 32'd401, "channel three time");
      rd_check(ADR_CAP_AUX, 32'd51, "aux channel time");
      $display("test concurrent done");
   endtask

   task automatic t_mux();
      thr <= {16'd240, 16'd180, 16'd120, 16'd60, 16'd30, 16'd20, 16'd10};
      for (int c = 0; c < 4; c++) begin
         wr(ADR_MODE, 32'h80 | 32'(c));
         check({30'h0, aux_select_o}, 32'(c), "selector output");
         rd_check(ADR_MODE, 32'h80 | 32'(c), "mode readback");
         conv();
         rd_check(ADR_CAP_AUX, 32'd61 + 32'(60 * c), "selected aux time");
      end
      $display("test mux done");
   endtask

   task automatic t_rate();
      logic [31:0] d;
      wr(ADR_MODE, 32'h00);
      thr <= {16'd0, 16'd0, 16'd0, 16'd0, 16'd0, 16'd0, 16'd200};
      conv();
      wb(1'b0, ADR_CAP_ONE, 32'h0, d);
      check({31'h0, d >= 32'd99 && d <= 32'd101}, 32'h1, "half rate time");
      rd_check(ADR_CAP_TWO, 32'h0, "untripped channel");
      $display("test rate done");
   endtask

   task automatic t_double();
      wr(ADR_PERIOD, 32'd1000);
      rd_check(ADR_PERIOD, 32'd1000, "period readback");
      wr(ADR_MODE, 32'h80);
      thr <= {16'd0, 16'd0, 16'd0, 16'd0, 16'd0, 16'd0, 16'd700};
      conv();
      rd_check(ADR_CAP_ONE, 32'd701, "single update time");
      wr(ADR_MODE, 32'h84);
      rd_check(ADR_MODE, 32'h84, "double mode readback");
      conv();
      rd_check(ADR_CAP_ONE, 32'h0, "double update too short");
      $display("test double done");
   endtask

   task automatic t_sat();
      wr(ADR_PERIOD, 32'h1388);
      wr(ADR_MODE, 32'h80);
      thr <= {16'd0, 16'd0, 16'd0, 16'd0, 16'd0, 16'd0, 16'd4500};
      conv();
      rd_check(ADR_CAP_ONE, 32'h0fff, "saturated time");
      $display("test saturation done");
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_trim();
      t_width();
      t_concurrent();
      t_mux();
      t_rate();
      t_double();
      t_sat();
      tally_and_finish();
   end

   // Watchdog well past the longest expected run
   initial begin
      repeat (60000) @(posedge clk_i);
      failures++;
      $display("unexpected at %0t ns: watchdog expired", $time);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// *** tb/ssat_ramp_model.sv ***
// Behavioural ramp and comparator bank at the far side of the converter timer.
// Assumes the restart pulse is sampled on clk_i and discharges the ramp at once.
`timescale 1ns/1ps
`default_nettype none
module ssat_ramp_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sync_i,
   input wire logic [6:0][15:0] thr_i,
   output logic [6:0] comp_o
);
   // ==========================================================
   // Ramp age in core cycles since the restart pulse ended
   logic [15:0] ramp_q; // Saturating ramp age

   // Ramp held discharged during the pulse, then rises
   always_ff @(posedge clk_i) begin
      if (rst_i || sync_i) begin
         ramp_q <= 16'h0000;
      end else if (ramp_q != 16'hffff) begin
         ramp_q <= ramp_q + 16'h0001;
      end
   end

   // ==========================================================
   // Comparators: high once the ramp passes the input, zero code never trips
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         comp_o[i] = !sync_i && (thr_i[i] != 16'h0000) && (ramp_q >= thr_i[i]);
      end
   end
endmodule
`default_nettype wire
